// file: rtl/wdt_reset_pkg.sv
package wdt_reset_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ           = 40_000_000;
   localparam int unsigned CLK_MHZ          = CLK_HZ / 1_000_000;
   localparam int unsigned SLOW_OSC_HZ      = 32_000;
   localparam int unsigned SRESET_NS        = 2_000;
   localparam int unsigned SRESET_CYCLES    = (SRESET_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned UV_FILTER_NS     = 120_000;
   localparam int unsigned UV_FILTER_CYCLES = (UV_FILTER_NS * CLK_MHZ + 999) / 1000;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_WATCHDOG_CONTROL   = 8'h00;
   localparam logic [7:0] ADDR_RESET_SOURCE_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_RESET_GUARD_CTRL   = 8'h08;
   localparam logic [7:0] ADDR_UNDERVOLT_LEVEL    = 8'h0C;
   localparam logic [7:0] ADDR_STATUS             = 8'h10;

   // ---------------------------------------------------------------
   // Fields, codes and power-up values
   // ---------------------------------------------------------------
   localparam int unsigned GUARD_MSB        = 7;
   localparam int unsigned GUARD_LSB        = 3;
   localparam int unsigned PERIOD_MSB       = 2;
   localparam logic [4:0]  GUARD_ENABLE     = 5'h0A;
   localparam logic [4:0]  GUARD_DISABLE    = 5'h15;
   localparam logic [7:0]  WATCHDOG_CONTROL_POR         = 8'h53;
   localparam logic [7:0]  RESET_GUARD_CONTROL_POR         = 8'h55;
   localparam logic [7:0]  RESET_GUARD_CONTROL_ALT         = 8'hAA;
   localparam logic [7:0]  UNDERVOLT_LEVEL_CONTROL_POR         = 8'h66;
   localparam logic [7:0]  LV_SEL_1V9       = 8'h55;
   localparam logic [7:0]  LV_SEL_2V55      = 8'h33;
   localparam logic [7:0]  LV_SEL_3V15      = 8'h99;
   localparam logic [7:0]  LV_SEL_3V8       = 8'hAA;
   localparam logic [7:0]  LV_SEL_OFF       = 8'hF0;
   localparam int unsigned FLAG_WDOG        = 0;
   localparam int unsigned FLAG_LEVEL       = 1;
   localparam int unsigned FLAG_UNDERVOLT   = 2;
   localparam int unsigned FLAG_GUARD       = 3;
   localparam int unsigned FLAG_BITS        = 4;
   localparam int unsigned STAT_TIMEOUT     = 0;
   localparam int unsigned STAT_POWERDOWN   = 1;
   localparam int unsigned SRC_WDOG         = 0;
   localparam int unsigned SRC_LEVEL        = 1;
   localparam int unsigned SRC_GUARD        = 2;
   localparam int unsigned WD_CNT_W         = 18;

   typedef enum logic {SEQ_IDLE, SEQ_WAIT} seq_state_type;

   // Terminal count of the watchdog for each period code
   function automatic logic [WD_CNT_W-1:0] period_limit(input logic [2:0] sel);
      case (sel)
         3'h0:    period_limit = 18'h000FF;
         3'h1:    period_limit = 18'h003FF;
         3'h2:    period_limit = 18'h00FFF;
         3'h3:    period_limit = 18'h03FFF;
         3'h4:    period_limit = 18'h07FFF;
         3'h5:    period_limit = 18'h0FFFF;
         3'h6:    period_limit = 18'h1FFFF;
         default: period_limit = 18'h3FFFF;
      endcase
   endfunction : period_limit

endpackage : wdt_reset_pkg

// file: rtl/sync_edge.sv
`timescale 1ns/1ps
module sync_edge (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic async_i,
   output logic      level_o,
   output logic      rise_o
);
   logic meta;
   logic stable;
   logic prev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta   <= 1'b0;
         stable <= 1'b0;
         prev   <= 1'b0;
      end else begin
         meta   <= async_i;
         stable <= meta;
         prev   <= stable;
      end
   end

   assign level_o = stable;
   assign rise_o  = stable & ~prev;
endmodule : sync_edge

// file: rtl/persist_filter.sv
`timescale 1ns/1ps
module persist_filter #(
   parameter int unsigned CYCLES = 4800
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic enable_i,
   input  wire logic level_i,
   output logic      fire_o
);
   localparam int unsigned CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES);

   logic [CNT_W-1:0] cnt;
   logic             fired;

   // Fires once when the level has stood longer than CYCLES
   always_ff @(posedge clk_i) begin
      if (rst_i || !enable_i || !level_i) begin
         cnt   <= '0;
         fired <= 1'b0;
      end else if (cnt != LAST) begin
         cnt <= cnt + 1'b1;
      end else begin
         fired <= 1'b1;
      end
   end

   assign fire_o = enable_i & level_i & (cnt == LAST) & ~fired;
endmodule : persist_filter

// file: rtl/watchdog_and_reset_control.sv
`timescale 1ns/1ps
// Summary of operation
// RULE1: Watchdog counts slow oscillator, divides power of two.
// RULE2: Period code picks 2^8 up to 2^18.
// RULE3: Guard 10101 disables, 01010 enables watchdog.
// RULE4: Other guard codes reset after delay, flag.
// RULE5: Watchdog control flag set by hardware, software clears.
// RULE6: Power-up loads guard enable, period code 011.
// RULE7: Overflow while running: full reset, timeout flag.
// RULE8: Overflow while asleep: timeout flag, clear PC, SP.
// RULE9: Clear, halt or guard reset zero the counter.
// RULE10: Reset guard register odd values reset after delay; code resets on every value except 01010101 and 10101010.
// RULE11: Power-up loads reset guard register 01010101.
// RULE12: Guard register reset sets its flag; software clears.
// RULE13: Upper four flag bits read as zero.
// RULE14: Undervolt reset active only outside sleep, idle.
// RULE15: Undervolt must persist beyond filter time.
// RULE16: Real undervolt reset sets its flag.
// RULE17: Undefined level code resets after delay, flag.
// RULE18: Power-up loads level selector 01100110.
// RULE19: Power-on presets ports to inputs, address zero.
// RULE20: Five thresholds plus off; others reset, restore selector.
// RULE21: Requests synchronous, held until delay counter expires.
module watchdog_and_reset_control
   import wdt_reset_pkg::*;
#(
   parameter int unsigned WB_ADR_W      = 8,
   parameter int unsigned SRESET_CYC    = SRESET_CYCLES,
   parameter int unsigned UV_FILTER_CYC = UV_FILTER_CYCLES
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic [WB_ADR_W-1:0] adr_i,
   input  wire logic [31:0]         dat_i,
   output logic      [31:0]         dat_o,
   input  wire logic                we_i,
   input  wire logic [3:0]          sel_i,
   input  wire logic                cyc_i,
   input  wire logic                stb_i,
   output logic                     ack_o,
   input  wire logic                slow_osc_i,
   input  wire logic                undervolt_i,
   input  wire logic                sleep_mode_i,
   input  wire logic                clear_instr_i,
   input  wire logic                halt_instr_i,
   output logic                     chip_reset_o,
   output logic                     pc_sp_clear_o,
   output logic                     port_preset_o
);
   import wdt_reset_pkg::*;

   localparam int unsigned DLY_W = $clog2(SRESET_CYC + 1);
   localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(SRESET_CYC - 1);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [7:0]          watchdog_control;
   logic [7:0]          reset_guard_control;
   logic [7:0]          undervolt_level_control;
   logic [FLAG_BITS-1:0] reset_source_flags;
   logic                timeout_flag;
   logic                powerdown_flag;
   logic [WD_CNT_W-1:0] wd_cnt;
   seq_state_type       seq_state;
   logic [DLY_W-1:0]    dly_cnt;
   logic [2:0]          src;
   logic                ack;
   logic                osc_rise;
   logic                uv_level;
   logic                uv_fire;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ---------------------------------------------------------------
   // Input synchronisers and undervolt filter
   // ---------------------------------------------------------------
   sync_edge u_osc_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (slow_osc_i),
      .level_o (),
      .rise_o  (osc_rise)
   );

   sync_edge u_uv_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (undervolt_i),
      .level_o (uv_level),
      .rise_o  ()
   );

   wire lv_threshold = (undervolt_level_control == UNDERVOLT_LEVEL_CONTROL_POR)
                     | (undervolt_level_control == LV_SEL_1V9)
                     | (undervolt_level_control == LV_SEL_2V55)
                     | (undervolt_level_control == LV_SEL_3V15)
                     | (undervolt_level_control == LV_SEL_3V8);
   wire lv_off       = (undervolt_level_control == LV_SEL_OFF);
   wire lv_bad       = ~lv_threshold & ~lv_off;                      // RULE20
   wire uv_enable    = lv_threshold & ~sleep_mode_i;                 // RULE14

   persist_filter #(
      .CYCLES (UV_FILTER_CYC)
   ) u_uv_filter (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .enable_i (uv_enable),
      .level_i  (uv_level),
      .fire_o   (uv_fire)                                            // RULE15
   );

   // ---------------------------------------------------------------
   // Wishbone slave
   // ---------------------------------------------------------------
   wire       wb_req    = cyc_i & stb_i;
   wire       wr_stb    = wb_req & we_i & ack & sel_i[0];
   wire [7:0] adr       = 8'(adr_i);
   wire       hit_watchdog_control  = (adr == ADDR_WATCHDOG_CONTROL);
   wire       hit_flags = (adr == ADDR_RESET_SOURCE_FLAGS);
   wire       hit_reset_guard_control  = (adr == ADDR_RESET_GUARD_CTRL);
   wire       hit_undervolt_level_control  = (adr == ADDR_UNDERVOLT_LEVEL);
   wire       hit_stat  = (adr == ADDR_STATUS);
   wire [7:0] stat_byte = {6'h00, powerdown_flag, timeout_flag};
   wire [7:0] rd_byte   = hit_watchdog_control  ? watchdog_control :
                          hit_flags ? {4'h0, reset_source_flags} :   // RULE13
                          hit_reset_guard_control  ? reset_guard_control :
                          hit_undervolt_level_control  ? undervolt_level_control :
                          hit_stat  ? stat_byte : 8'h00;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack   <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack <= wb_req & ~ack;
         if (wb_req && !ack) begin
            dat_o <= {24'h00_0000, rd_byte};
         end
      end
   end

   assign ack_o = ack;

   a_flags_high_zero: assert property (                              // RULE13
      ack_o && hit_flags && !we_i |-> dat_o[31:FLAG_BITS] == '0)
      else $error("reset flag upper bits not zero");

   // ---------------------------------------------------------------
   // Guard checks and delayed reset sequencer
   // ---------------------------------------------------------------
   wire [4:0] guard      = watchdog_control[GUARD_MSB:GUARD_LSB];
   wire       guard_on   = (guard == GUARD_ENABLE);                  // RULE3
   wire       guard_bad  = ~guard_on & (guard != GUARD_DISABLE);     // RULE4
   wire       reset_guard_control_bad   = (reset_guard_control != RESET_GUARD_CONTROL_POR)
                         & (reset_guard_control != RESET_GUARD_CONTROL_ALT);        // RULE10
   wire [2:0] bad_vec    = {reset_guard_control_bad, lv_bad, guard_bad};
   wire       seq_expire = (seq_state == SEQ_WAIT) && (dly_cnt == DLY_LAST);
   wire [2:0] fire_src   = seq_expire ? (src | bad_vec) : 3'h0;

   // Request latched and held until the delay expires
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_state <= SEQ_IDLE;
         dly_cnt   <= '0;
         src       <= 3'h0;
      end else begin
         case (seq_state)
            SEQ_IDLE: begin
               dly_cnt <= '0;
               src     <= bad_vec;
               if (bad_vec != 3'h0) begin
                  seq_state <= SEQ_WAIT;                             // RULE21
               end
            end
            SEQ_WAIT: begin
               src     <= src | bad_vec;
               dly_cnt <= dly_cnt + 1'b1;
               if (seq_expire) begin
                  seq_state <= SEQ_IDLE;
                  src       <= 3'h0;
               end
            end
            default: begin
               seq_state <= SEQ_IDLE;
            end
         endcase
      end
   end

   a_delay_fires: assert property (                                  // RULE21
      seq_state == SEQ_WAIT && dly_cnt == DLY_LAST |=> chip_reset_o)
      else $error("delayed reset did not fire at terminal count");
   a_no_early_reset: assert property (                               // RULE10
      seq_state == SEQ_IDLE && $rose(reset_guard_control_bad) && !uv_fire
      |=> !chip_reset_o ##1 !chip_reset_o)
      else $error("guard register reset fired without delay");

   // ---------------------------------------------------------------
   // Watchdog counter
   // ---------------------------------------------------------------
   wire [WD_CNT_W-1:0] wd_limit = period_limit(watchdog_control[PERIOD_MSB:0]);
   wire wd_tick     = osc_rise & guard_on;                           // RULE1
   wire wd_overflow = wd_tick & (wd_cnt >= wd_limit);                // RULE2
   wire wd_clear    = clear_instr_i | halt_instr_i
                    | fire_src[SRC_WDOG] | chip_reset_o;

   always_ff @(posedge clk_i) begin
      if (rst_i || wd_clear || !guard_on) begin
         wd_cnt <= '0;                                               // RULE9
      end else if (wd_tick) begin
         wd_cnt <= wd_overflow ? '0 : wd_cnt + 1'b1;
      end
   end

   a_overflow_restart: assert property (                             // RULE1
      wd_overflow |=> wd_cnt == '0)
      else $error("watchdog count not restarted after overflow");
   a_disabled_stops: assert property (                               // RULE3
      guard == GUARD_DISABLE |=> wd_cnt == '0)
      else $error("disabled watchdog still counting");
   a_clear_counter: assert property (                                // RULE9
      clear_instr_i || halt_instr_i |=> wd_cnt == '0)
      else $error("clear or halt did not zero watchdog");

   // ---------------------------------------------------------------
   // Reset outputs
   // ---------------------------------------------------------------
   wire next_chip_reset = (fire_src != 3'h0)                         // RULE4
                        | (wd_overflow & ~sleep_mode_i)              // RULE7
                        | uv_fire;                                   // RULE16
   wire next_pc_sp_clr  = wd_overflow & sleep_mode_i;                // RULE8

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chip_reset_o  <= 1'b0;
         pc_sp_clear_o <= 1'b0;
         port_preset_o <= 1'b1;                                      // RULE19
      end else begin
         chip_reset_o  <= next_chip_reset;
         pc_sp_clear_o <= next_pc_sp_clr;
         port_preset_o <= next_chip_reset;
      end
   end

   a_run_timeout: assert property (                                  // RULE7
      wd_overflow && !sleep_mode_i |=> chip_reset_o && timeout_flag)
      else $error("running timeout missed reset or flag");
   a_sleep_timeout: assert property (                                // RULE8
      wd_overflow && sleep_mode_i && !uv_fire && fire_src == 3'h0
      |=> pc_sp_clear_o && !chip_reset_o && timeout_flag)
      else $error("sleep timeout wrong reset kind");
   a_port_preset: assert property (                                  // RULE19
      chip_reset_o |-> port_preset_o)
      else $error("ports not preset with chip reset");

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         watchdog_control        <= WATCHDOG_CONTROL_POR;                        // RULE6
         reset_guard_control     <= RESET_GUARD_CONTROL_POR;                        // RULE11
         undervolt_level_control <= UNDERVOLT_LEVEL_CONTROL_POR;                        // RULE18
      end else begin
         if (fire_src[SRC_WDOG]) begin
            watchdog_control <= WATCHDOG_CONTROL_POR;
         end else if (wr_stb && hit_watchdog_control) begin
            watchdog_control <= dat_i[7:0];
         end
         if (fire_src[SRC_GUARD]) begin
            reset_guard_control <= RESET_GUARD_CONTROL_POR;
         end else if (wr_stb && hit_reset_guard_control) begin
            reset_guard_control <= dat_i[7:0];
         end
         if (fire_src[SRC_LEVEL]) begin
            undervolt_level_control <= UNDERVOLT_LEVEL_CONTROL_POR;                     // RULE20
         end else if (wr_stb && hit_undervolt_level_control) begin
            undervolt_level_control <= dat_i[7:0];
         end
      end
   end

   a_por_values: assert property (                                   // RULE6
      $past(rst_i) |-> watchdog_control == WATCHDOG_CONTROL_POR
                    && reset_guard_control == RESET_GUARD_CONTROL_POR
                    && undervolt_level_control == UNDERVOLT_LEVEL_CONTROL_POR)
      else $error("power-up register values wrong");

   // ---------------------------------------------------------------
   // Reset source flags and status flags
   // ---------------------------------------------------------------
   wire [FLAG_BITS-1:0] flag_set;
   assign flag_set[FLAG_WDOG]      = fire_src[SRC_WDOG];             // RULE5
   assign flag_set[FLAG_LEVEL]     = fire_src[SRC_LEVEL];            // RULE17
   assign flag_set[FLAG_UNDERVOLT] = uv_fire;                        // RULE16
   assign flag_set[FLAG_GUARD]     = fire_src[SRC_GUARD];            // RULE12
   wire flag_wr = wr_stb & hit_flags;

   // Set wins over a software clear; writing one leaves a flag alone
   genvar gi;
   generate
      for (gi = 0; gi < FLAG_BITS; gi = gi + 1) begin : g_flag
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               reset_source_flags[gi] <= 1'b0;
            end else begin
               reset_source_flags[gi] <= flag_set[gi]
                  | (reset_source_flags[gi] & ~(flag_wr & ~dat_i[gi]));
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timeout_flag   <= 1'b0;
         powerdown_flag <= 1'b0;
      end else begin
         timeout_flag   <= wd_overflow
                         | (timeout_flag & ~clear_instr_i & ~halt_instr_i);
         powerdown_flag <= halt_instr_i | (powerdown_flag & ~clear_instr_i);
      end
   end

   a_wdog_flag: assert property (                                    // RULE5
      fire_src[SRC_WDOG] |=> chip_reset_o && reset_source_flags[FLAG_WDOG]
                             && watchdog_control == WATCHDOG_CONTROL_POR)
      else $error("guard code reset missed flag or restore");
   a_flag_sticky: assert property (                                  // RULE5
      reset_source_flags[FLAG_WDOG] && !flag_wr |=> reset_source_flags[FLAG_WDOG])
      else $error("watchdog reset flag lost without software clear");
   a_reset_guard_control_flag: assert property (                                    // RULE12
      fire_src[SRC_GUARD] |=> reset_source_flags[FLAG_GUARD] && chip_reset_o)
      else $error("guard register reset flag not set");
   a_level_restore: assert property (                                // RULE17
      fire_src[SRC_LEVEL] |=> undervolt_level_control == UNDERVOLT_LEVEL_CONTROL_POR
                              && reset_source_flags[FLAG_LEVEL])
      else $error("level selector not restored or flag missing");
   a_uv_reset: assert property (                                     // RULE16
      uv_fire |=> chip_reset_o && reset_source_flags[FLAG_UNDERVOLT])
      else $error("undervolt reset missed flag or reset");
   a_uv_sleep_off: assert property (                                 // RULE14
      sleep_mode_i |-> !uv_fire)
      else $error("undervolt reset fired while asleep");

   c_guard_reset: cover property (fire_src[SRC_WDOG]);
   c_run_timeout: cover property (wd_overflow && !sleep_mode_i);
   c_sleep_timeout: cover property (wd_overflow && sleep_mode_i);
   c_undervolt: cover property (uv_fire);

endmodule : watchdog_and_reset_control

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import wdt_reset_pkg::*;
   logic        clk_i, rst_i, we_i, cyc_i, stb_i, slow_osc_i, undervolt_i;
   logic        sleep_mode_i, clear_instr_i, halt_instr_i, osc_run;
   logic [7:0]  adr_i;
   logic [31:0] dat_i, rd;
   logic [3:0]  sel_i;
   logic [1:0]  osc_div;
   wire  [31:0] dat_o;
   wire         ack_o, chip_reset_o, pc_sp_clear_o, port_preset_o;
   int          n_mismatch, n_checks, i;
   localparam logic [47:0] LV_CODES = 48'h5533_99AA_F066;

   watchdog_and_reset_control #(.SRESET_CYC(4), .UV_FILTER_CYC(8)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
      .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .slow_osc_i(slow_osc_i), .undervolt_i(undervolt_i), .sleep_mode_i(sleep_mode_i),
      .clear_instr_i(clear_instr_i), .halt_instr_i(halt_instr_i),
      .chip_reset_o(chip_reset_o), .pc_sp_clear_o(pc_sp_clear_o),
      .port_preset_o(port_preset_o));

   // ------------------------------------------------------------
   // Clock and slow oscillator, one rising tick per 8 clocks
   // ------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      osc_div <= osc_div + 2'h1;
      if (osc_run && osc_div == 2'h3) slow_osc_i <= ~slow_osc_i;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk

   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      int k;
      @(posedge clk_i);
      adr_i <= a;
      we_i  <= w;
      dat_i <= {24'h000000, d};
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 50);
      rd = dat_o;
      if (k >= 50) n_mismatch++;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask : wb

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      wb(a, 1'b0, 8'h00);
      chk({24'h000000, exp}, rd);
   endtask : rdchk

   // Waits for a reset pulse; exp is {port preset, pc/sp clear, chip reset}
   task automatic fire(input int lim, input logic [2:0] exp);
      int k;
      for (k = 0; k < lim; k++) begin
         @(posedge clk_i);
         if (chip_reset_o === 1'b1 || pc_sp_clear_o === 1'b1) break;
      end
      chk({29'h0, exp}, {29'h0, port_preset_o, pc_sp_clear_o, chip_reset_o});
   endtask : fire

   task automatic pulse(input logic halt);
      @(posedge clk_i);
      if (halt) halt_instr_i <= 1'b1;
      else clear_instr_i <= 1'b1;
      @(posedge clk_i);
      halt_instr_i  <= 1'b0;
      clear_instr_i <= 1'b0;
   endtask : pulse

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      {rst_i, we_i, cyc_i, stb_i, slow_osc_i, undervolt_i} = 6'b100000;
      {sleep_mode_i, clear_instr_i, halt_instr_i, osc_run} = 4'h0;
      adr_i = 8'h00; dat_i = 32'h0; sel_i = 4'h1; osc_div = 2'h0; rd = 32'h0;
      repeat (16) @(posedge clk_i);
      chk(32'h0000_0001, {31'h0, port_preset_o});
      rst_i <= 1'b0;
      rdchk(ADDR_WATCHDOG_CONTROL, 8'h53);
      rdchk(ADDR_RESET_GUARD_CTRL, 8'h55);
      rdchk(ADDR_UNDERVOLT_LEVEL, 8'h66);
      rdchk(ADDR_RESET_SOURCE_FLAGS, 8'h00);
      rdchk(ADDR_STATUS, 8'h00);
      wb(8'h14, 1'b1, 8'hFF);
      rdchk(8'h14, 8'h00);
      wb(ADDR_WATCHDOG_CONTROL, 1'b1, 8'h03);
      fire(3, 3'b000);
      fire(20, 3'b101);
      rdchk(ADDR_WATCHDOG_CONTROL, 8'h53);
      rdchk(ADDR_RESET_SOURCE_FLAGS, 8'h01);
      wb(ADDR_RESET_GUARD_CTRL, 1'b1, 8'hAA);
      fire(20, 3'b000);
      wb(ADDR_RESET_GUARD_CTRL, 1'b1, 8'h12);
      fire(20, 3'b101);
      rdchk(ADDR_RESET_GUARD_CTRL, 8'h55);
      wb(ADDR_RESET_SOURCE_FLAGS, 1'b1, 8'hFE);
      rdchk(ADDR_RESET_SOURCE_FLAGS, 8'h08);
      wb(ADDR_RESET_SOURCE_FLAGS, 1'b1, 8'h00);
      for (i = 0; i < 6; i++) begin
         wb(ADDR_UNDERVOLT_LEVEL, 1'b1, LV_CODES[8*(5-i) +: 8]);
         fire(12, 3'b000);
         rdchk(ADDR_UNDERVOLT_LEVEL, LV_CODES[8*(5-i) +: 8]);
      end
      wb(ADDR_UNDERVOLT_LEVEL, 1'b1, 8'h01);
      fire(20, 3'b101);
      rdchk(ADDR_UNDERVOLT_LEVEL, 8'h66);
      rdchk(ADDR_RESET_SOURCE_FLAGS, 8'h02);
      wb(ADDR_RESET_SOURCE_FLAGS, 1'b1, 8'h00);
      undervolt_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      undervolt_i <= 1'b0;
      fire(20, 3'b000);
      sleep_mode_i <= 1'b1;
      undervolt_i  <= 1'b1;
      fire(30, 3'b000);
      sleep_mode_i <= 1'b0;
      fire(30, 3'b101);
      undervolt_i <= 1'b0;
      rdchk(ADDR_RESET_SOURCE_FLAGS, 8'h04);
      rdchk(ADDR_UNDERVOLT_LEVEL, 8'h66);
      wb(ADDR_WATCHDOG_CONTROL, 1'b1, 8'h50);
      osc_run <= 1'b1;
      pulse(1'b0);
      fire(1950, 3'b000);
      fire(200, 3'b101);
      rdchk(ADDR_STATUS, 8'h01);
      sleep_mode_i <= 1'b1;
      pulse(1'b0);
      fire(1950, 3'b000);
      fire(200, 3'b010);
      rdchk(ADDR_STATUS, 8'h01);
      pulse(1'b1);
      rdchk(ADDR_STATUS, 8'h02);
      sleep_mode_i <= 1'b0;
      wb(ADDR_WATCHDOG_CONTROL, 1'b1, 8'hA8);
      fire(2300, 3'b000);
      osc_run <= 1'b0;
      close_out();
   end

   initial begin
      #1ms;
      n_mismatch++;
      close_out();
   end
endmodule : tb_top
